// file: wdtrl_defines.svh
// Purpose: constants for the watchdog reload lock and timeout block
// Assumes: 8-bit internal register bus, one write strobe per access
// Notes:   offsets are internal write selects, not bus addresses
`ifndef WDTRL_DEFINES_SVH
`define WDTRL_DEFINES_SVH

// ============================================================
// register selects
`define WDTRL_SEL_CTL    2'h0
`define WDTRL_SEL_UPPER  2'h1
`define WDTRL_SEL_HIGH   2'h2
`define WDTRL_SEL_LOW    2'h3

// ============================================================
// unlock keys and control fields
`define WDTRL_KEY_FIRST  8'h55
`define WDTRL_KEY_SECOND 8'hAA
`define WDTRL_BIT_TOFLAG 7
`define WDTRL_BIT_STOPFL 6
`define WDTRL_CTL_RESET  8'h00

// ============================================================
// reload and counter
`define WDTRL_RELOAD_RST 24'hFFFFFF
`define WDTRL_RELOAD_RST_U 8'hFF
`define WDTRL_RELOAD_RST_H 8'hFF
`define WDTRL_RELOAD_RST_L 8'hFF
`define WDTRL_CNT_ONE    24'h000001

`endif

// file: wdtrl_pkg.sv
// Purpose: types for the watchdog reload lock and timeout block
// Assumes: used together with wdtrl_defines.svh
// Notes:   lock states are one-hot
package wdtrl_pkg;
   typedef enum logic [4:0] {
      WDTRL_LOCKED  = 5'b00001,
      WDTRL_KEY1    = 5'b00010,
      WDTRL_OPEN_U  = 5'b00100,
      WDTRL_OPEN_H  = 5'b01000,
      WDTRL_OPEN_L  = 5'b10000
   } wdtrl_lock_t;
endpackage

// file: wdtrl_counter.sv
// Purpose: watchdog down counter with reload
// Assumes: reload value is stable while counting
// Notes:   timeout is a one-cycle pulse when the count reaches one
`timescale 1ns/10ps
`default_nettype none
`include "wdtrl_defines.svh"
module wdtrl_counter (
   input  wire logic        ref_clk,     // system clock
   input  wire logic        sys_rst,     // sync reset, high
   input  wire logic        enable,      // counter runs while high
   input  wire logic        load,        // reload request
   input  wire logic [23:0] reloadVal,   // value to load
   output logic             timeout,     // one-cycle timeout pulse
   output logic      [23:0] count        // current count
);
   // ============================================================
   // counting; a load wins over a decrement so a refresh is never lost
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count   <= `WDTRL_RELOAD_RST;
         timeout <= 1'b0;
      end else if (load) begin
         count   <= reloadVal;
         timeout <= 1'b0;
      end else if (enable) begin
         if (count <= `WDTRL_CNT_ONE) begin
            count   <= reloadVal;       // restart after expiry
            timeout <= 1'b1;
         end else begin
            count   <= count - `WDTRL_CNT_ONE;
            timeout <= 1'b0;
         end
      end else begin
         timeout <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: wdtrl_top.sv
// Purpose: watchdog timeout handling and reload register unlock
// Assumes: core presents one write per strobe; stop mode and
//          interrupt enable come from the core as levels
// Notes:   no bus; register writes arrive as select, data, strobe
`timescale 1ns/10ps
`default_nettype none
`include "wdtrl_defines.svh"

module wdtrl_top
   import wdtrl_pkg::*;
(
   input  wire logic        ref_clk,        // 25 MHz system clock
   input  wire logic        sys_rst,        // sync reset, high
   input  wire logic        regWrite,       // register write strobe
   input  wire logic  [1:0] regSel,         // register select
   input  wire logic  [7:0] regWdata,       // write data
   input  wire logic        wdtEnable,      // watchdog enable level
   input  wire logic        refreshInstr,   // refresh instruction pulse
   input  wire logic        resetMode,      // 1 reset, 0 interrupt
   input  wire logic        inStopMode,     // chip is in stop mode
   input  wire logic        intEnabled,     // core interrupts enabled
   input  wire logic        recoveryDone,   // stop recovery complete
   output logic       [7:0] watchdog_control_reg, // control/status
   output logic       [7:0] reload_upper_byte,    // reload upper
   output logic       [7:0] reload_high_byte,     // reload high
   output logic       [7:0] reload_low_byte,      // reload low
   output logic             shortReset,     // short reset pulse
   output logic             stopRecovery,   // stop recovery pulse
   output logic             wdtIrq,         // interrupt request pulse
   output logic             vectorFetch,    // take watchdog vector pulse
   output logic             unlocked,       // reload bytes writable
   output logic      [23:0] wdtCount        // counter value
);
   // ============================================================
   // internal state and decoded strobes
   wdtrl_lock_t lockState;        // present lock step
   wdtrl_lock_t next_lockState;   // lock step after this write
   logic        enableDly;        // enable level one clock ago
   logic        timeout;          // counter expiry pulse
   logic        wakePending;      // stop wake waiting for recovery
   logic        ctlWrite;         // write aimed at the control register
   logic        isKey;            // write data is one of the two keys
   logic        firstKey;         // control write of the first key
   logic        secondKey;        // control write of the second key
   logic        upperWr;          // upper byte write in its open step
   logic        highWr;           // high byte write in its open step
   logic        lowWr;            // low byte write in its open step
   logic        enableRise;       // watchdog has just been enabled
   logic        counterLoad;      // reload request to the counter
   logic [23:0] reloadVal;        // joined reload value

   // ============================================================
   // write decode; the keys only count when they land on the control select
   assign ctlWrite  = regWrite && (regSel == `WDTRL_SEL_CTL);
   assign isKey     = (regWdata == `WDTRL_KEY_FIRST) || (regWdata == `WDTRL_KEY_SECOND);
   assign firstKey  = ctlWrite && (regWdata == `WDTRL_KEY_FIRST);
   assign secondKey = ctlWrite && (regWdata == `WDTRL_KEY_SECOND);
   assign reloadVal = {reload_upper_byte, reload_high_byte, reload_low_byte};
   assign unlocked  = (lockState != WDTRL_LOCKED) && (lockState != WDTRL_KEY1);

   // reload byte strobes: a byte is taken only in the step that opens it,
   // so a stray write can never slip a byte in ahead of its turn
   assign upperWr   = regWrite && (lockState == WDTRL_OPEN_U) && (regSel == `WDTRL_SEL_UPPER);
   assign highWr    = regWrite && (lockState == WDTRL_OPEN_H) && (regSel == `WDTRL_SEL_HIGH);
   assign lowWr     = regWrite && (lockState == WDTRL_OPEN_L) && (regSel == `WDTRL_SEL_LOW);

   // ============================================================
   // lock machine: any write that does not match the next step relocks
   always_comb begin
      next_lockState = lockState;
      if (regWrite) begin
         unique case (lockState)
            WDTRL_LOCKED: begin
               // only the first key on the control select starts the sequence
               if (firstKey) begin
                  next_lockState = WDTRL_KEY1;
               end else begin
                  next_lockState = WDTRL_LOCKED;
               end
            end
            WDTRL_KEY1: begin
               if (secondKey) begin
                  next_lockState = WDTRL_OPEN_U;
               end else begin
                  next_lockState = WDTRL_LOCKED;
               end
            end
            WDTRL_OPEN_U: begin
               if (regSel == `WDTRL_SEL_UPPER) begin
                  next_lockState = WDTRL_OPEN_H;
               end else begin
                  next_lockState = WDTRL_LOCKED;
               end
            end
            WDTRL_OPEN_H: begin
               if (regSel == `WDTRL_SEL_HIGH) begin
                  next_lockState = WDTRL_OPEN_L;
               end else begin
                  next_lockState = WDTRL_LOCKED;
               end
            end
            // any write here ends the sequence, the low byte or a stray one
            WDTRL_OPEN_L: begin
               next_lockState = WDTRL_LOCKED;
            end
            // a broken one-hot code falls back to the safe locked step
            default: begin
               next_lockState = WDTRL_LOCKED;
            end
         endcase
      end
   end

   // lock step register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lockState <= WDTRL_LOCKED;
      end else begin
         lockState <= next_lockState;
      end
   end

   // ============================================================
   // reload bytes; writes outside the open step are simply dropped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reload_upper_byte <= `WDTRL_RELOAD_RST_U;
         reload_high_byte  <= `WDTRL_RELOAD_RST_H;
         reload_low_byte   <= `WDTRL_RELOAD_RST_L;
      end else begin
         if (upperWr) begin
            reload_upper_byte <= regWdata;
         end
         if (highWr) begin
            reload_high_byte <= regWdata;
         end
         if (lowWr) begin
            reload_low_byte <= regWdata;
         end
      end
   end

   // ============================================================
   // counter; loaded on the rising edge of enable and on refresh
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         enableDly <= 1'b0;
      end else begin
         enableDly <= wdtEnable;
      end
   end

   // a refresh while disabled is ignored so a stopped watchdog keeps its count
   assign enableRise  = wdtEnable && !enableDly;
   assign counterLoad = enableRise || (wdtEnable && refreshInstr);

   wdtrl_counter uCounter (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .enable    (wdtEnable),
      .load      (counterLoad),
      .reloadVal (reloadVal),
      .timeout   (timeout),
      .count     (wdtCount)
   );

   // ============================================================
   // control/status; key writes touch nothing, a timeout set wins over a clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         watchdog_control_reg <= `WDTRL_CTL_RESET;
      end else begin
         // writing 1 to a flag clears it; the two keys clear nothing
         if (ctlWrite && !isKey) begin
            watchdog_control_reg <= watchdog_control_reg & ~regWdata;
         end
         if (timeout && resetMode) begin
            watchdog_control_reg[`WDTRL_BIT_TOFLAG] <= 1'b1;
            if (inStopMode) begin
               watchdog_control_reg[`WDTRL_BIT_STOPFL] <= 1'b1;
            end
         end
      end
   end

   // ============================================================
   // timeout actions; stop mode always recovers first, so reset and
   // interrupt are both kept to normal running
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shortReset   <= 1'b0;
         stopRecovery <= 1'b0;
         wdtIrq       <= 1'b0;
      end else begin
         shortReset   <= timeout && resetMode && !inStopMode;
         stopRecovery <= timeout && inStopMode;
         wdtIrq       <= timeout && !resetMode && !inStopMode;
      end
   end

   // ============================================================
   // vector fetch held until recovery finishes so the core takes it afterwards
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wakePending <= 1'b0;
         vectorFetch <= 1'b0;
      end else begin
         vectorFetch <= wakePending && recoveryDone && intEnabled;
         if (timeout && inStopMode && !resetMode) begin
            wakePending <= 1'b1;
         end else if (recoveryDone) begin
            wakePending <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: wdtrl_top_properties.sv
// Purpose: port-level properties of the watchdog reload lock and timeout block
// Assumes: one clock domain, sync reset high
// Notes:   bound onto wdtrl_top from the bench top file
`timescale 1ns/10ps
`default_nettype none
`include "wdtrl_defines.svh"
// ============================================================
// checker
module wdtrl_top_properties (
   input wire logic        ref_clk, sys_rst, regWrite,                   // clock, reset, strobe
   input wire logic        wdtEnable, resetMode, inStopMode,             // levels
   input wire logic [1:0]  regSel,                                       // select
   input wire logic [7:0]  regWdata, watchdog_control_reg,               // data, control
   input wire logic [7:0]  reload_upper_byte, reload_high_byte, reload_low_byte, // reload
   input wire logic        shortReset, stopRecovery, wdtIrq, unlocked,   // events
   input wire logic [23:0] wdtCount                                      // count
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   logic        ctlWr;
   logic [23:0] reloadVal;
   // decoded write and joined reload value
   assign ctlWr = regWrite && regSel == `WDTRL_SEL_CTL;
   assign reloadVal = {reload_upper_byte, reload_high_byte, reload_low_byte};
   // a timeout landing on a key write may still set flags
   AST_KEY_NO_EFFECT:
      assert property (ctlWr && regWdata inside {`WDTRL_KEY_FIRST, `WDTRL_KEY_SECOND}
         |=> $stable(watchdog_control_reg) || shortReset || stopRecovery) else $error("key write changed control");
   AST_KEYS_UNLOCK:
      assert property (!regWrite ##1 (!unlocked && ctlWr && regWdata == `WDTRL_KEY_FIRST)
         ##1 (ctlWr && regWdata == `WDTRL_KEY_SECOND) |=> unlocked) else $error("keys did not unlock");
   AST_STRAY_RELOCK:
      assert property (unlocked && ctlWr |=> !unlocked) else $error("stray write left lock open");
   AST_LOCKED_REFUSE:
      assert property (!unlocked && regWrite && !ctlWr |=> $stable(reloadVal)) else $error("locked reload written");
   AST_ENABLE_LOAD:
      assert property ($rose(wdtEnable) |=> wdtCount == $past(reloadVal)) else $error("enable did not load count");
   AST_RESET_FLAG:
      assert property (shortReset |-> watchdog_control_reg[`WDTRL_BIT_TOFLAG] && resetMode && !inStopMode)
         else $error("short reset without flag");
   AST_STOP_FLAGS:
      assert property (stopRecovery && resetMode |-> watchdog_control_reg[7:6] == 2'h3 && !shortReset)
         else $error("stop timeout flags wrong");
   AST_IRQ_NORMAL:
      assert property (wdtIrq |-> !resetMode && !inStopMode && !shortReset) else $error("irq in wrong mode");
endmodule
`default_nettype wire

// file: wdtrl_core_model.sv
// Purpose: stop recovery sequencer standing on the far side of the watchdog
// Assumes: recovery lasts LAT system clocks
// Notes:   a new start while busy restarts the wait
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// recovery model
module wdtrl_core_model #(parameter int LAT = 4) (
   input  wire logic ref_clk,      // system clock
   input  wire logic sys_rst,      // sync reset, high
   input  wire logic stopRecovery, // recovery start pulse
   output logic      recoveryDone  // one-cycle done pulse
);
   int left;
   // count down the recovery time, done pulses on the last cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst || stopRecovery) begin
         left <= sys_rst ? 0 : LAT;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   assign recoveryDone = (left == 1);
endmodule
`default_nettype wire

// file: watchdog_reload_lock_and_timeout_bench.sv
// Purpose: self-checking bench for the watchdog reload lock and timeout block
// Assumes: reload shortened to twelve so timeouts come quickly
// Notes:   consecutive wr calls give back-to-back writes
`timescale 1ns/10ps
`default_nettype none
`include "wdtrl_defines.svh"
// ============================================================
// bench top
module watchdog_reload_lock_and_timeout_bench;
   logic        ref_clk = 0, sys_rst = 1, regWrite = 0, wdtEnable = 0, refreshInstr = 0;
   logic        resetMode = 1, inStopMode = 0, intEnabled = 0, recoveryDone;
   logic        shortReset, stopRecovery, wdtIrq, vectorFetch, unlocked;
   logic [1:0]  regSel = 0;
   logic [7:0]  regWdata = 0, ctl, up, hi, lo;
   logic [23:0] wdtCount;
   int          n_errors = 0, tests_run = 0;
   wire logic [3:0] evt = {vectorFetch, wdtIrq, stopRecovery, shortReset};
   always #20 ref_clk = ~ref_clk;
   wdtrl_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .regWrite(regWrite), .regSel(regSel),
      .regWdata(regWdata), .wdtEnable(wdtEnable), .refreshInstr(refreshInstr), .resetMode(resetMode),
      .inStopMode(inStopMode), .intEnabled(intEnabled), .recoveryDone(recoveryDone),
      .watchdog_control_reg(ctl), .reload_upper_byte(up), .reload_high_byte(hi), .reload_low_byte(lo),
      .shortReset(shortReset), .stopRecovery(stopRecovery), .wdtIrq(wdtIrq), .vectorFetch(vectorFetch),
      .unlocked(unlocked), .wdtCount(wdtCount));
   wdtrl_core_model #(.LAT(4)) model_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .stopRecovery(stopRecovery), .recoveryDone(recoveryDone));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1;
      regSel <= sel;
      regWdata <= d;
   endtask
   // drop the strobe, then let the last write become visible
   task automatic idle;
      @(posedge ref_clk);
      regWrite <= 0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic reload(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_FIRST);
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_SECOND);
      wr(`WDTRL_SEL_UPPER, u);
      wr(`WDTRL_SEL_HIGH, h);
      wr(`WDTRL_SEL_LOW, l);
      idle;
   endtask
   // bounded wait for one event pulse; a miss ends the run
   task automatic waitEv(input int b);
      for (int i = 0; i < 100; i++) begin
         @(posedge ref_clk);
         #1;
         if (evt[b] === 1'b1) return;
      end
      n_errors++;
      results;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 0;
      #1;
      check({up, hi, lo}, `WDTRL_RELOAD_RST);
      check(wdtCount, `WDTRL_RELOAD_RST);
      $display("test reset values done");
      reload(8'h12, 8'h34, 8'h56);
      check({up, hi, lo}, 24'h123456);
      check({unlocked, 15'h0000, ctl}, 24'h000000);
      // out-of-order byte relocks, so the following bytes are dropped
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_FIRST);
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_SECOND);
      wr(`WDTRL_SEL_HIGH, 8'h00);
      wr(`WDTRL_SEL_UPPER, 8'h00);
      wr(`WDTRL_SEL_LOW, 8'h0C);
      idle;
      check({up, hi, lo}, 24'h123456);
      reload(8'h00, 8'h00, 8'h0C);
      check({up, hi, lo}, 24'h00000C);
      $display("test unlock and reload done");
      @(posedge ref_clk);
      wdtEnable <= 1;
      @(posedge ref_clk);
      #1;
      check(wdtCount, 24'h00000C);
      waitEv(0);
      check({16'h0000, ctl}, 24'h000080);
      @(posedge ref_clk);
      inStopMode <= 1;
      wr(`WDTRL_SEL_CTL, 8'h80);
      idle;
      waitEv(1);
      check({16'h0000, ctl}, 24'h0000C0);
      // keys with both flags up: a write-1-clear must not reach them
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_FIRST);
      wr(`WDTRL_SEL_CTL, `WDTRL_KEY_SECOND);
      idle;
      check({16'h0000, ctl}, 24'h0000C0);
      check({23'h000000, unlocked}, 24'h000001);
      $display("test reset mode timeouts done");
      @(posedge ref_clk);
      resetMode <= 0;
      inStopMode <= 0;
      // a control write while open relocks, so the upper byte is dropped
      wr(`WDTRL_SEL_CTL, 8'hC0);
      wr(`WDTRL_SEL_UPPER, 8'h77);
      idle;
      check({23'h000000, unlocked}, 24'h000000);
      check({up, hi, lo}, 24'h00000C);
      waitEv(2);
      check({22'h000000, shortReset, wdtIrq}, 24'h000001);
      @(posedge ref_clk);
      inStopMode <= 1;
      intEnabled <= 1;
      waitEv(3);
      check({22'h000000, wdtIrq, vectorFetch}, 24'h000001);
      $display("test interrupt mode timeouts done");
      @(posedge ref_clk);
      inStopMode <= 0;
      refreshInstr <= 1;
      @(posedge ref_clk);
      refreshInstr <= 0;
      #1;
      check(wdtCount, 24'h00000C);
      $display("test refresh done");
      results;
   end
endmodule
bind wdtrl_top wdtrl_top_properties chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .regWrite(regWrite),
   .wdtEnable(wdtEnable), .resetMode(resetMode), .inStopMode(inStopMode), .regSel(regSel),
   .regWdata(regWdata), .watchdog_control_reg(watchdog_control_reg), .reload_upper_byte(reload_upper_byte),
   .reload_high_byte(reload_high_byte), .reload_low_byte(reload_low_byte), .shortReset(shortReset),
   .stopRecovery(stopRecovery), .wdtIrq(wdtIrq), .unlocked(unlocked), .wdtCount(wdtCount));
`default_nettype wire
